/* verilog/esbt_regs.vh */
/*
 * Constants of the external static bus timing controller: field widths,
 * area count, reset levels and recovery condition encoding.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ESBT_REGS_VH
`define ESBT_REGS_VH

// Number of chip-select areas and width of an area index
`define ESBT_AREAS 4
`define ESBT_AREA_W 2
// Width of every wait, delay and hold count (0 to 31 cycles)
`define ESBT_WAIT_W 5
// Width of the recovery length (1 to 15 cycles, 0 acts as 1)
`define ESBT_RECOV_W 4
// Recovery enable: bit index is {prev_write, next_write, other_area}
`define ESBT_RECOV_CONDS 8
// Address and data widths
`define ESBT_ADDR_W 24
`define ESBT_DATA_W 16
// Reset values
`define ESBT_RDATA_RST 16'h0000
`define ESBT_ADDR_RST 24'h000000

`endif

/* verilog/esbt_lane.v */
/*
 * Byte-lane decoder for one bus piece: which data-bus lanes carry valid
 * bytes for the area's width, byte order and the piece's address.
 * Assumes pieces are either an aligned 16-bit word or a single byte.
 */
`timescale 1ns/1ps
`default_nettype none

module esbt_lane (
    input wire wide16,
    input wire big_endian,
    input wire word_piece,
    input wire addr0,
    output wire lane_lo,
    output wire lane_hi
);

    wire byte_hi;

    // Byte on high lane of a 16-bit area: odd address little-endian, even address big-endian
    assign byte_hi = wide16 & (addr0 ^ big_endian);
    assign lane_hi = wide16 & (word_piece | byte_hi);
    assign lane_lo = word_piece | ~byte_hi;

endmodule // esbt_lane

`default_nettype wire

/* verilog/esbt_ctrl.v */
/*
 * External static-memory bus controller with four chip-select areas.
 * Each access runs through access and, if set, hold phases, with recovery first
 * when enabled; edges are placed by counting cycles against per-area settings and one shared recovery length.
 * Assumes requests and settings are synchronous to CLOCK and that the
 * requester keeps REQ and its fields steady until REQ_DONE.
 */
`timescale 1ns/1ps
`default_nettype none
`include "esbt_regs.vh"

module esbt_ctrl #(
    parameter AREAS = `ESBT_AREAS,
    parameter WW = `ESBT_WAIT_W
) (
    input wire CLOCK,
    input wire RESETN,
    input wire REQ,
    input wire REQ_WRITE,
    input wire REQ_WORD,
    input wire [`ESBT_AREA_W-1:0] REQ_AREA,
    input wire [`ESBT_ADDR_W-1:0] REQ_ADDR,
    input wire [`ESBT_DATA_W-1:0] REQ_WDATA,
    output reg REQ_DONE,
    output reg [`ESBT_DATA_W-1:0] REQ_RDATA,
    output reg BUSY,
    input wire [AREAS*WW-1:0] CFG_CS_ASSERT_DELAY,
    input wire [AREAS*WW-1:0] CFG_READ_STROBE_ASSERT_DELAY,
    input wire [AREAS*WW-1:0] CFG_READ_CYCLE_WAIT,
    input wire [AREAS*WW-1:0] CFG_READ_CS_HOLD,
    input wire [AREAS*WW-1:0] CFG_WRITE_DATA_OUT_DELAY,
    input wire [AREAS*WW-1:0] CFG_WRITE_STROBE_ASSERT_DELAY,
    input wire [AREAS*WW-1:0] CFG_WRITE_DATA_HOLD,
    input wire [AREAS*WW-1:0] CFG_WRITE_CYCLE_WAIT,
    input wire [AREAS*WW-1:0] CFG_WRITE_CS_HOLD,
    input wire [AREAS-1:0] CFG_AREA_WIDE16,
    input wire [AREAS-1:0] CFG_AREA_BIG_ENDIAN,
    input wire CFG_BYTE_STROBE_MODE,
    input wire [`ESBT_RECOV_W-1:0] CFG_RECOVERY_CYCLES,
    input wire [`ESBT_RECOV_CONDS-1:0] CFG_RECOVERY_ENABLE,
    input wire WAIT_N,
    input wire [`ESBT_DATA_W-1:0] DATA_I,
    output reg [`ESBT_ADDR_W-1:0] ADDR,
    output reg [AREAS-1:0] AREA_SELECT_N,
    output reg READ_STROBE_N,
    output reg WRITE_STROBE_N,
    output reg LOW_LANE_WRITE_STROBE_N,
    output reg HIGH_LANE_WRITE_STROBE_N,
    output reg LOW_LANE_SELECT_N,
    output reg HIGH_LANE_SELECT_N,
    output reg [`ESBT_DATA_W-1:0] DATA_O,
    output reg DATA_OE
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_ACCESS = 2'h1;
    localparam [1:0] S_HOLD = 2'h2;
    localparam [1:0] S_RECOV = 2'h3;

    reg [1:0] state, next_state;
    reg [WW-1:0] cnt, next_cnt;
    reg [`ESBT_AREA_W-1:0] area, next_area, prev_area, next_prev_area;
    reg wr, next_wr, prev_wr, next_prev_wr, prev_valid, next_prev_valid;
    reg split, next_split, second, next_second, word, next_word;
    reg [`ESBT_ADDR_W-1:0] addr, next_addr;
    reg [`ESBT_DATA_W-1:0] wdata, next_wdata, next_rdata;
    reg next_done;
    reg go, p_wr, p_valid;
    reg [`ESBT_AREA_W-1:0] p_area;
    reg [WW-1:0] c_cs, c_strobe, c_wait, c_cshold, c_dout, c_dhold, c_hold;
    reg [WW-1:0] rec_len;
    reg [7:0] byte_in, byte_out;
    reg cs_on, rd_on, wr_on, d_on;
    wire cur_lo, cur_hi, nxt_lo, nxt_hi;

    ////////////////////////////////////////////////////////////////////////
    // Lane decode for the piece in progress and for the coming piece
    esbt_lane u_lane_cur (
        .wide16(CFG_AREA_WIDE16[area]),
        .big_endian(CFG_AREA_BIG_ENDIAN[area]),
        .word_piece(word),
        .addr0(addr[0]),
        .lane_lo(cur_lo),
        .lane_hi(cur_hi)
    );

    esbt_lane u_lane_nxt (
        .wide16(CFG_AREA_WIDE16[next_area]),
        .big_endian(CFG_AREA_BIG_ENDIAN[next_area]),
        .word_piece(next_word),
        .addr0(next_addr[0]),
        .lane_lo(nxt_lo),
        .lane_hi(nxt_hi)
    );

    ////////////////////////////////////////////////////////////////////////
    // Settings of the area and direction of the coming cycle
    always @* begin
        c_cs = CFG_CS_ASSERT_DELAY[next_area*WW +: WW];
        if (next_wr) begin
            c_strobe = CFG_WRITE_STROBE_ASSERT_DELAY[next_area*WW +: WW];
            c_wait = CFG_WRITE_CYCLE_WAIT[next_area*WW +: WW];
            c_cshold = CFG_WRITE_CS_HOLD[next_area*WW +: WW];
            c_dout = CFG_WRITE_DATA_OUT_DELAY[next_area*WW +: WW];
            c_dhold = CFG_WRITE_DATA_HOLD[next_area*WW +: WW];
        end else begin
            c_strobe = CFG_READ_STROBE_ASSERT_DELAY[next_area*WW +: WW];
            c_wait = CFG_READ_CYCLE_WAIT[next_area*WW +: WW];
            c_cshold = CFG_READ_CS_HOLD[next_area*WW +: WW];
            c_dout = {WW{1'b0}};
            c_dhold = {WW{1'b0}};
        end
        // Hold phase covers the longer of select hold and data hold
        c_hold = (c_dhold > c_cshold) ? c_dhold : c_cshold;
        rec_len = (CFG_RECOVERY_CYCLES == {`ESBT_RECOV_W{1'b0}}) ?
            {{(WW-`ESBT_RECOV_W){1'b0}}, 4'h1} :
            {{(WW-`ESBT_RECOV_W){1'b0}}, CFG_RECOVERY_CYCLES};
    end

    ////////////////////////////////////////////////////////////////////////
    // Read byte taken from the piece's lane, write byte for the piece
    always @* begin
        byte_in = cur_hi ? DATA_I[15:8] : DATA_I[7:0];
        // First piece of a split word is the low-address byte
        if (next_split && (next_second ^ CFG_AREA_BIG_ENDIAN[next_area]))
            byte_out = next_wdata[15:8];
        else
            byte_out = next_wdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: request take, access, hold, split and recovery
    always @* begin
        next_state = state;
        next_cnt = cnt;
        next_area = area;
        next_wr = wr;
        next_addr = addr;
        next_wdata = wdata;
        next_split = split;
        next_second = second;
        next_word = word;
        next_prev_area = prev_area;
        next_prev_wr = prev_wr;
        next_prev_valid = prev_valid;
        next_rdata = REQ_RDATA;
        next_done = 1'b0;
        go = 1'b0;
        p_wr = prev_wr;
        p_area = prev_area;
        p_valid = prev_valid;
        case (state)
            S_IDLE: begin
                if (REQ && !REQ_DONE) begin
                    go = 1'b1;
                    next_area = REQ_AREA;
                    next_wr = REQ_WRITE;
                    next_addr = REQ_ADDR;
                    next_wdata = REQ_WDATA;
                    next_second = 1'b0;
                    next_split = REQ_WORD &
                        (~CFG_AREA_WIDE16[REQ_AREA] | REQ_ADDR[0]);
                    next_word = REQ_WORD & ~next_split;
                    next_rdata = `ESBT_RDATA_RST;
                end
            end
            S_ACCESS: begin
                if (cnt < c_wait) begin
                    next_cnt = cnt + 1'b1;
                end else if (WAIT_N) begin
                    if (!wr) begin
                        if (word)
                            next_rdata = DATA_I;
                        else if (!split)
                            next_rdata = {8'h00, byte_in};
                        else if (second ^ CFG_AREA_BIG_ENDIAN[area])
                            next_rdata[15:8] = byte_in;
                        else
                            next_rdata[7:0] = byte_in;
                    end
                    next_cnt = {WW{1'b0}};
                    if (c_hold != {WW{1'b0}})
                        next_state = S_HOLD;
                    else
                        next_state = S_IDLE;
                end
            end
            S_HOLD: begin
                if (cnt + 1'b1 < c_hold)
                    next_cnt = cnt + 1'b1;
                else
                    next_state = S_IDLE;
            end
            default: begin
                if (cnt + 1'b1 < rec_len) begin
                    next_cnt = cnt + 1'b1;
                end else begin
                    next_cnt = {WW{1'b0}};
                    next_state = S_ACCESS;
                end
            end
        endcase
        // End of a piece: record it, then run the second half or finish
        if (state != S_IDLE && state != S_RECOV && next_state == S_IDLE) begin
            next_prev_area = area;
            next_prev_wr = wr;
            next_prev_valid = 1'b1;
            p_wr = wr;
            p_area = area;
            p_valid = 1'b1;
            if (split && !second) begin
                go = 1'b1;
                next_second = 1'b1;
                next_addr = addr + 1'b1;
            end else begin
                next_done = 1'b1;
            end
        end
        // Start of a piece, with recovery when its condition is enabled
        if (go) begin
            next_cnt = {WW{1'b0}};
            if (p_valid && CFG_RECOVERY_ENABLE[{p_wr, next_wr,
                    p_area != next_area}])
                next_state = S_RECOV;
            else
                next_state = S_ACCESS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels for the coming cycle
    always @* begin
        cs_on = (next_state == S_ACCESS && next_cnt >= c_cs) ||
            (next_state == S_HOLD && next_cnt < c_cshold);
        rd_on = next_state == S_ACCESS && !next_wr &&
            next_cnt >= c_strobe;
        wr_on = next_state == S_ACCESS && next_wr &&
            next_cnt >= c_strobe;
        d_on = next_wr && ((next_state == S_ACCESS &&
            next_cnt >= c_dout) ||
            (next_state == S_HOLD && next_cnt < c_dhold));
    end

    ////////////////////////////////////////////////////////////////////////
    // State and output flip-flops
    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state <= S_IDLE;
            cnt <= {WW{1'b0}};
            area <= {`ESBT_AREA_W{1'b0}};
            prev_area <= {`ESBT_AREA_W{1'b0}};
            wr <= 1'b0;
            prev_wr <= 1'b0;
            prev_valid <= 1'b0;
            split <= 1'b0;
            second <= 1'b0;
            word <= 1'b0;
            addr <= `ESBT_ADDR_RST;
            wdata <= `ESBT_RDATA_RST;
            REQ_DONE <= 1'b0;
            REQ_RDATA <= `ESBT_RDATA_RST;
            BUSY <= 1'b0;
            ADDR <= `ESBT_ADDR_RST;
            AREA_SELECT_N <= {AREAS{1'b1}};
            READ_STROBE_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            LOW_LANE_WRITE_STROBE_N <= 1'b1;
            HIGH_LANE_WRITE_STROBE_N <= 1'b1;
            LOW_LANE_SELECT_N <= 1'b1;
            HIGH_LANE_SELECT_N <= 1'b1;
            DATA_O <= `ESBT_RDATA_RST;
            DATA_OE <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            area <= next_area;
            prev_area <= next_prev_area;
            wr <= next_wr;
            prev_wr <= next_prev_wr;
            prev_valid <= next_prev_valid;
            split <= next_split;
            second <= next_second;
            word <= next_word;
            addr <= next_addr;
            wdata <= next_wdata;
            REQ_DONE <= next_done;
            REQ_RDATA <= next_rdata;
            BUSY <= next_state != S_IDLE;
            ADDR <= next_addr;
            AREA_SELECT_N <= ~({{(AREAS-1){1'b0}}, cs_on} << next_area);
            READ_STROBE_N <= ~rd_on;
            // Byte-strobe mode: one strobe per written lane
            WRITE_STROBE_N <= ~(wr_on & ~CFG_BYTE_STROBE_MODE);
            LOW_LANE_WRITE_STROBE_N <= ~(wr_on & CFG_BYTE_STROBE_MODE &
                nxt_lo);
            HIGH_LANE_WRITE_STROBE_N <= ~(wr_on & CFG_BYTE_STROBE_MODE &
                nxt_hi);
            // Single-strobe mode: lane selects of the piece's lanes follow the area select
            LOW_LANE_SELECT_N <= ~(cs_on & ~CFG_BYTE_STROBE_MODE &
                nxt_lo);
            HIGH_LANE_SELECT_N <= ~(cs_on & ~CFG_BYTE_STROBE_MODE &
                nxt_hi);
            DATA_O <= next_word ? next_wdata : {byte_out, byte_out};
            DATA_OE <= d_on;
        end
    end

endmodule // esbt_ctrl

`default_nettype wire

/* sim/esbt_ctrl_asserts.sv */
/* Pin protocol checker bound into esbt_ctrl.
   Assumes settings keep select delay <= strobe delays. */
`timescale 1ns/1ps
`default_nettype none
`include "esbt_regs.vh"
module esbt_chk #(
    parameter AREAS = `ESBT_AREAS
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic REQ,
    input wire logic REQ_DONE,
    input wire logic BUSY,
    input wire logic CFG_BYTE_STROBE_MODE,
    input wire logic WAIT_N,
    input wire logic [AREAS-1:0] AREA_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic LOW_LANE_WRITE_STROBE_N,
    input wire logic HIGH_LANE_WRITE_STROBE_N,
    input wire logic LOW_LANE_SELECT_N,
    input wire logic HIGH_LANE_SELECT_N,
    input wire logic DATA_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // Any write strobe of either mode, any area selected
    wire wr_act = ~(WRITE_STROBE_N & LOW_LANE_WRITE_STROBE_N
        & HIGH_LANE_WRITE_STROBE_N);
    wire sel_act = ~&AREA_SELECT_N;
    ////////////////////
    // Memory asks for two cycles of stretch
    sequence s_stall;
        !WAIT_N [*2];
    endsequence
    property p_onehot; $onehot0(~AREA_SELECT_N); endproperty
    property p_rd; !READ_STROBE_N |-> sel_act && !wr_act && !DATA_OE;
    endproperty
    property p_wr; wr_act |-> sel_act && DATA_OE; endproperty
    property p_bs; CFG_BYTE_STROBE_MODE |-> WRITE_STROBE_N
        && LOW_LANE_SELECT_N && HIGH_LANE_SELECT_N; endproperty
    property p_single; !CFG_BYTE_STROBE_MODE |-> LOW_LANE_WRITE_STROBE_N
        && HIGH_LANE_WRITE_STROBE_N; endproperty
    property p_wait; s_stall ##0 !READ_STROBE_N |=> !READ_STROBE_N;
    endproperty
    property p_done; REQ_DONE |-> (!sel_act && !DATA_OE) ##1 !REQ_DONE;
    endproperty
    property p_take; $rose(BUSY) |-> $past(REQ); endproperty
    property p_idle; !BUSY |-> !sel_act && READ_STROBE_N && !wr_act;
    endproperty
    a_onehot: assert property (p_onehot) else $error("two selects");
    a_rd: assert property (p_rd) else $error("bad read strobe");
    a_wr: assert property (p_wr) else $error("bad write");
    a_bs: assert property (p_bs) else $error("bad lane mode");
    a_single: assert property (p_single) else $error("lane strobe");
    a_wait: assert property (p_wait) else $error("no stretch");
    a_done: assert property (p_done) else $error("bad done");
    a_take: assert property (p_take) else $error("busy without request");
    a_idle: assert property (p_idle) else $error("pins active when idle");
endmodule // esbt_chk
bind esbt_ctrl esbt_chk #(.AREAS(AREAS)) u_esbt_chk (.*);
`default_nettype wire

/* sim/esbt_mem.sv */
/* Behavioural static memory facing esbt_ctrl, byte lanes kept apart.
   Assumes STALL is set by the bench between accesses. */
`timescale 1ns/1ps
`default_nettype none
module esbt_mem (
    input wire logic CLOCK,
    input wire logic [23:0] ADDR,
    input wire logic [3:0] AREA_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic LOW_LANE_WRITE_STROBE_N,
    input wire logic HIGH_LANE_WRITE_STROBE_N,
    input wire logic LOW_LANE_SELECT_N,
    input wire logic HIGH_LANE_SELECT_N,
    input wire logic [15:0] DATA_O,
    input wire logic DATA_OE,
    input wire logic [3:0] STALL,
    output logic [15:0] DATA_I,
    output logic WAIT_N = 1'b1
);
    logic [7:0] lo [0:255];
    logic [7:0] hi [0:255];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    wire sel = ~&AREA_SELECT_N;
    wire [7:0] a = ADDR[7:0];
    // Lane written by own strobe or common strobe with lane select
    wire wlo = ~LOW_LANE_WRITE_STROBE_N
        | ~(WRITE_STROBE_N | LOW_LANE_SELECT_N);
    wire whi = ~HIGH_LANE_WRITE_STROBE_N
        | ~(WRITE_STROBE_N | HIGH_LANE_SELECT_N);
    ////////////////////
    // Level-sensitive write while selected and driven
    always @(posedge CLOCK) begin
        if (sel && DATA_OE && wlo) lo[a] <= DATA_O[7:0];
        if (sel && DATA_OE && whi) hi[a] <= DATA_O[15:8];
        last <= DATA_I;
    end
    // Prompt read data, a toggling pattern when not read
    assign DATA_I = (sel && !READ_STROBE_N) ? {hi[a], lo[a]} : ~last;
    // Slow answer: wait held low for STALL cycles of a selection
    always @(posedge CLOCK) begin
        cnt <= sel ? cnt + ((cnt < STALL) ? 4'h1 : 4'h0) : 4'h0;
        WAIT_N <= !(sel && cnt < STALL);
    end
endmodule // esbt_mem
`default_nettype wire

/* sim/tb_esbt_ctrl.sv */
/* Self-checking bench of esbt_ctrl with the memory model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_esbt_ctrl;
    logic CLOCK = 1'b0;
    logic RESETN = 1'b0;
    logic REQ = 1'b0;
    logic REQ_WRITE = 1'b0;
    logic REQ_WORD = 1'b0;
    logic [1:0] REQ_AREA = 2'h0;
    logic [23:0] REQ_ADDR = 24'h0;
    logic [15:0] REQ_WDATA = 16'h0;
    logic [19:0] CFG_CS_ASSERT_DELAY = {5'h3, 5'h2, 5'h1, 5'h0};
    logic [19:0] CFG_READ_STROBE_ASSERT_DELAY = {5'h4, 5'h3, 5'h2, 5'h1};
    logic [19:0] CFG_READ_CYCLE_WAIT = {5'h6, 5'h5, 5'h4, 5'h3};
    logic [19:0] CFG_READ_CS_HOLD = {4{5'h1}};
    logic [19:0] CFG_WRITE_DATA_OUT_DELAY = {4{5'h1}};
    logic [19:0] CFG_WRITE_DATA_HOLD = {4{5'h1}};
    logic [19:0] CFG_WRITE_CS_HOLD = {4{5'h2}};
    logic [3:0] CFG_AREA_WIDE16 = 4'h7;
    logic [3:0] CFG_AREA_BIG_ENDIAN = 4'h2;
    logic CFG_BYTE_STROBE_MODE = 1'b0;
    logic [3:0] CFG_RECOVERY_CYCLES = 4'h3;
    logic [7:0] CFG_RECOVERY_ENABLE = 8'h00;
    logic [3:0] STALL = 4'h0;
    wire logic REQ_DONE, BUSY, WAIT_N, READ_STROBE_N, WRITE_STROBE_N, DATA_OE;
    wire logic LOW_LANE_WRITE_STROBE_N, HIGH_LANE_WRITE_STROBE_N;
    wire logic LOW_LANE_SELECT_N, HIGH_LANE_SELECT_N;
    wire logic [15:0] REQ_RDATA, DATA_I, DATA_O;
    wire logic [23:0] ADDR;
    wire logic [3:0] AREA_SELECT_N;
    int mismatches = 0;
    int n_tests = 0;
    int cnt[5] = '{default: 0};
    // Both strobe delays and both waits share one setting
    esbt_ctrl u_esbt_ctrl (
        .*,
        .CFG_WRITE_STROBE_ASSERT_DELAY(CFG_READ_STROBE_ASSERT_DELAY),
        .CFG_WRITE_CYCLE_WAIT(CFG_READ_CYCLE_WAIT)
    );
    esbt_mem u_esbt_mem (.*);
    initial begin
        forever #2.5 CLOCK = ~CLOCK;
    end
    // Cycle counts: select, strobe, drive, low lane, high lane
    always @(posedge CLOCK) begin
        cnt[0] <= cnt[0] + int'(!AREA_SELECT_N[REQ_AREA]);
        cnt[1] <= cnt[1] + int'(!(READ_STROBE_N & WRITE_STROBE_N
            & LOW_LANE_WRITE_STROBE_N & HIGH_LANE_WRITE_STROBE_N));
        cnt[2] <= cnt[2] + int'(DATA_OE);
        cnt[3] <= cnt[3]
            + int'(!(LOW_LANE_WRITE_STROBE_N & LOW_LANE_SELECT_N));
        cnt[4] <= cnt[4]
            + int'(!(HIGH_LANE_WRITE_STROBE_N & HIGH_LANE_SELECT_N));
    end
    ////////////////////
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One request; area a has wait a+3, strobe delay a+1, select delay a
    task automatic acc(input logic w, wd, input logic [1:0] a,
            input logic [23:0] ad, input logic [15:0] d, input int np, rec,
            input logic [1:0] el);
        int n;
        int e;
        int c0[5];
        n = 0;
        // Take edge, recovery, pieces, then the edge that shows done
        e = 2 + rec + np * (a + 4 + (w ? 2 : 1));
        @(posedge CLOCK);
        REQ <= 1'b1;
        REQ_WRITE <= w;
        REQ_WORD <= wd;
        REQ_AREA <= a;
        REQ_ADDR <= ad;
        REQ_WDATA <= d;
        c0 = cnt;
        do begin
            @(posedge CLOCK);
            n++;
        end while (REQ_DONE !== 1'b1 && n < 400);
        REQ <= 1'b0;
        if (STALL == 4'h0) begin
            chk(n, e);
            chk(cnt[0] - c0[0], np * (w ? 6 : 5));
            chk(cnt[1] - c0[1], np * 3);
            chk(cnt[2] - c0[2], w ? np * (a + 4) : 0);
        end else
            chk(32'(n > e), 32'h1);
        if (w)
            chk({30'h0, cnt[4] != c0[4], cnt[3] != c0[3]}, el);
        else
            chk(REQ_RDATA, d);
    endtask
    // Write then read back, byte reads return zero-extended data
    task automatic wr_rd(input logic wd, input logic [1:0] a,
            input logic [23:0] ad, input logic [15:0] d, input int np, rec,
            input logic [1:0] el);
        acc(1'b1, wd, a, ad, d, np, 0, el);
        acc(1'b0, wd, a, ad, wd ? d : {8'h00, d[7:0]}, np, rec, el);
    endtask
    initial begin
        repeat (6) @(posedge CLOCK);
        RESETN <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            @(posedge CLOCK);
            CFG_BYTE_STROBE_MODE <= m[0];
            for (int a = 0; a < 4; a++)
                if (m == 1 || a != 3)
                    wr_rd(1'b1, a[1:0], 24'(m * 128 + a * 32 + 16),
                        16'(16'h1234 * (a + 2 * m + 1)), (a == 3) ? 2 : 1, 0,
                        (a == 3) ? 2'b01 : 2'b11);
        end
        wr_rd(1'b1, 2'h0, 24'h000001, 16'hbeef, 2, 0, 2'b11);
        // Low address of a split word holds its low byte when little endian
        acc(1'b0, 1'b0, 2'h0, 24'h000001, 16'h00ef, 1, 0, 2'b10);
        wr_rd(1'b1, 2'h1, 24'h000041, 16'hcafe, 2, 0, 2'b11);
        // And its high byte when big endian
        acc(1'b0, 1'b0, 2'h1, 24'h000041, 16'h00ca, 1, 0, 2'b01);
        wr_rd(1'b0, 2'h0, 24'h000011, 16'h0077, 1, 0, 2'b10);
        wr_rd(1'b0, 2'h1, 24'h000021, 16'h0066, 1, 0, 2'b01);
        wr_rd(1'b0, 2'h3, 24'h000032, 16'h0055, 1, 0, 2'b01);
        STALL <= 4'h4;
        wr_rd(1'b1, 2'h2, 24'h000062, 16'h5aa5, 1, 0, 2'b11);
        STALL <= 4'h0;
        CFG_RECOVERY_ENABLE <= 8'h10;
        wr_rd(1'b1, 2'h0, 24'h000064, 16'h3c5a, 1, 3, 2'b11);
        print_verdict;
    end
    // Run needs a few hundred cycles; cut off far beyond that
    initial begin
        #200000;
        mismatches++;
        print_verdict;
    end
endmodule // tb_esbt_ctrl
`default_nettype wire
